// ==== inc/alert_pkg.sv ====
// What this block does
// - Every status read returns the status register's address code in bits 15 to 12.
// - A register write rejected for a checksum mismatch sets the write check flag at bit 9.
// - The write check flag and all channel alert flags stay set until the status is read or reset code 3C or FF clears them.
// - A failed startup configuration load sets the load fail flag at bit 8.
// - A status read leaves the load fail flag alone; only a hard reset clears it and restarts setup.
// - A result above its high threshold sets the over flag of channel D, C or B at bit 7, 5 or 3.
// - A result below its low threshold sets the under flag of channel D, C or B at bit 6, 4 or 2.
// - Channel A has a sticky over flag at bit 1 and a sticky under flag at bit 0.
// - Reset code 3C clears all flags but the load fail flag; code FF clears all flags and the interrupt enables.
// - The low threshold is the 12-bit field followed by four zero bits, high by four ones.
// Purpose: Constants, offsets and carriers for the alert status block.
// Assumes: 32-bit Avalon-MM slave with byte addresses.
// Notes: Channel n owns under bit 2n and over bit 2n+1.
package alert_pkg;
  localparam int NCHAN = 4;
  localparam int FLAG_W = 10;
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_RESET = 5'h04;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFF_IRQ_CLR = 5'h0C;
  localparam logic [4:0] OFF_IRQ_EN = 5'h10;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 12;
  localparam int RSV_HI = 11;
  localparam int RSV_LO = 10;
  localparam int BIT_WCHK = 9;
  localparam int BIT_SETUP = 8;
  // Arbitrary code reported in the address field of the status word.
  localparam logic [3:0] STATUS_ADDR_CODE = 4'h4;
  localparam logic [7:0] RST_SOFT = 8'h3C;
  localparam logic [7:0] RST_HARD = 8'hFF;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [3:0] HIGH_PAD = 4'hF;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 10'h000;
  localparam logic [FLAG_W-1:0] SETUP_MASK = 10'h100;
  localparam logic [FLAG_W-1:0] STICKY_MASK = 10'h2FF;

  typedef logic [NCHAN-1:0][15:0] chan_results_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_s;

  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] irq_stat;
    logic [FLAG_W-1:0] irq_en;
    logic [FLAG_W-1:0] snap;
    logic ack;
    logic restart;
    logic [31:0] rdata;
  } state_s;
endpackage

// ==== rtl/alert_status_flags.sv ====
// Purpose: Sticky fault and threshold alert flags with read-to-clear.
// Assumes: Event inputs are one-cycle pulses synchronous to MCLK.
// Notes: Each access ends one cycle after it is presented.
`timescale 1ns/1ps
`default_nettype none
module alert_status_flags
  import alert_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire avs_req_s AVS,
  output logic AVS_WAITREQUEST,
  output logic [31:0] AVS_READDATA,
  input wire logic CRC_REJECT,
  input wire logic SETUP_LOAD_FAIL,
  input wire logic RESULT_VALID,
  input wire chan_results_t CHAN_RESULT,
  input wire logic [11:0] LOW_FIELD,
  input wire logic [11:0] HIGH_FIELD,
  output logic SETUP_RESTART,
  output logic IRQ
);

  // Expand a 12-bit threshold field into the internal 16-bit value.
  function automatic logic [15:0] thr16(input logic [11:0] fld,
                                        input logic [3:0] pad);
    thr16 = {fld, pad};
  endfunction

  state_s s;
  state_s next_s;
  logic [FLAG_W-1:0] set_vec;
  logic [NCHAN-1:0] over_now;
  logic [NCHAN-1:0] under_now;
  logic req;
  logic take;
  logic status_take;
  logic soft_take;
  logic hard_take;

  // Threshold compares, one pair per channel.
  genvar ch;
  generate
    for (ch = 0; ch < NCHAN; ch++) begin : g_cmp
      assign over_now[ch] = RESULT_VALID &&
        (CHAN_RESULT[ch] > thr16(HIGH_FIELD, HIGH_PAD));
      assign under_now[ch] = RESULT_VALID &&
        (CHAN_RESULT[ch] < thr16(LOW_FIELD, LOW_PAD));
      assign set_vec[2*ch+1] = over_now[ch];
      assign set_vec[2*ch] = under_now[ch];
    end
  endgenerate

  // Fault events land on their fixed bit positions.
  assign set_vec[BIT_WCHK] = CRC_REJECT;
  assign set_vec[BIT_SETUP] = SETUP_LOAD_FAIL;

  // A request is taken on the cycle its waitrequest is low.
  assign req = AVS.read || AVS.write;
  assign take = req && s.ack;
  assign status_take = take && AVS.read && (AVS.address == OFF_STATUS);
  assign soft_take = take && AVS.write && (AVS.address == OFF_RESET) &&
                     AVS.byteenable[0] && (AVS.writedata[7:0] == RST_SOFT);
  assign hard_take = take && AVS.write && (AVS.address == OFF_RESET) &&
                     AVS.byteenable[0] && (AVS.writedata[7:0] == RST_HARD);

  // Next state: bus answer, flag update and interrupt bookkeeping.
  always_comb begin
    logic [FLAG_W-1:0] clr;
    clr = '0;
    next_s = s;
    next_s.restart = 1'b0;
    next_s.ack = req && !s.ack;
    // Read data is built a cycle ahead so it comes from a flop.
    if (req && !s.ack) begin
      next_s.rdata = '0;
      if (AVS.read) begin
        unique case (AVS.address)
          OFF_STATUS: begin
            next_s.rdata[ADDR_HI:ADDR_LO] = STATUS_ADDR_CODE;
            next_s.rdata[FLAG_W-1:0] = s.flags;
            next_s.snap = s.flags;
          end
          OFF_IRQ_STAT: next_s.rdata[FLAG_W-1:0] = s.irq_stat;
          OFF_IRQ_EN: next_s.rdata[FLAG_W-1:0] = s.irq_en;
          default: next_s.rdata = '0;
        endcase
      end
    end
    // Only bits the host actually saw are cleared by the read.
    if (status_take) begin
      clr = s.snap & STICKY_MASK;
    end
    if (soft_take) begin
      clr = STICKY_MASK;
    end
    if (hard_take) begin
      clr = {FLAG_W{1'b1}};
      next_s.restart = 1'b1;
      next_s.irq_en = FLAGS_RESET;
    end
    // New events win over any clear in the same cycle.
    next_s.flags = (s.flags & ~clr) | set_vec;
    next_s.irq_stat = s.irq_stat | set_vec;
    if (take && AVS.write && AVS.address == OFF_IRQ_CLR &&
        AVS.byteenable[0]) begin
      next_s.irq_stat[7:0] = (s.irq_stat[7:0] & ~AVS.writedata[7:0]) |
                             set_vec[7:0];
    end
    if (take && AVS.write && AVS.address == OFF_IRQ_CLR &&
        AVS.byteenable[1]) begin
      next_s.irq_stat[FLAG_W-1:8] =
        (s.irq_stat[FLAG_W-1:8] & ~AVS.writedata[FLAG_W-1:8]) |
        set_vec[FLAG_W-1:8];
    end
    if (take && AVS.write && AVS.address == OFF_IRQ_EN && !hard_take) begin
      if (AVS.byteenable[0]) begin
        next_s.irq_en[7:0] = AVS.writedata[7:0];
      end
      if (AVS.byteenable[1]) begin
        next_s.irq_en[FLAG_W-1:8] = AVS.writedata[FLAG_W-1:8];
      end
    end
  end

  // All state registers together; reset loads constants only.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Waitrequest is combinational so every access costs one wait cycle.
  assign AVS_WAITREQUEST = req && !s.ack;
  assign AVS_READDATA = s.rdata;
  assign SETUP_RESTART = s.restart;
  assign IRQ = |(s.irq_stat & s.irq_en);

  // Steps of a status read, of a quiet event cycle and of a waited request.
  sequence s_status_read;
    AVS.read && AVS.address == OFF_STATUS && !AVS_WAITREQUEST;
  endsequence

  sequence s_quiet;
    !CRC_REJECT && !RESULT_VALID && !SETUP_LOAD_FAIL;
  endsequence

  sequence s_request_wait;
    req && AVS_WAITREQUEST ##1 req && !AVS_WAITREQUEST;
  endsequence

  a_addr_field: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read |-> AVS_READDATA[ADDR_HI:ADDR_LO] == STATUS_ADDR_CODE)
    else $error("status address field wrong");

  a_wchk_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    CRC_REJECT |=> s.flags[BIT_WCHK])
    else $error("write check flag not set");

  a_sticky_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(s.flags[BIT_WCHK]) |-> $past(status_take || soft_take ||
                                       hard_take))
    else $error("write check flag dropped without read");

  a_setup_set: assert property (@(posedge MCLK) disable iff (!RST_N)
    SETUP_LOAD_FAIL |=> s.flags[BIT_SETUP])
    else $error("load fail flag not set");

  a_setup_keep: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(s.flags[BIT_SETUP]) |-> $past(hard_take) && SETUP_RESTART)
    else $error("load fail flag cleared without hard reset");

  a_over_d: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[3] > {HIGH_FIELD, 4'hF} |=> s.flags[7])
    else $error("channel D over flag missing");

  a_under_d: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[3] < {LOW_FIELD, 4'h0} |=> s.flags[6])
    else $error("channel D under flag missing");

  a_chan_a_flags: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[0] < {LOW_FIELD, 4'h0} |=> s.flags[0])
    else $error("channel A under flag missing");

  a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read |-> AVS_READDATA[RSV_HI:RSV_LO] == 2'h0 &&
                      AVS_READDATA[31:16] == 16'h0000)
    else $error("reserved status bits not zero");

  a_soft_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    soft_take ##0 s_quiet |=> (s.flags & STICKY_MASK) == '0 &&
                              s.flags[BIT_SETUP] == $past(s.flags[BIT_SETUP]))
    else $error("soft reset clear wrong");

  a_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read ##0 CRC_REJECT |=> s.flags[BIT_WCHK])
    else $error("new event lost to read clear");

  a_one_wait: assert property (@(posedge MCLK) disable iff (!RST_N)
    req && !s.ack |-> s_request_wait)
    else $error("access did not end after one wait cycle");

  // Channel C and B over flags use the same padded high threshold.
  a_over_c: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[2] > thr16(HIGH_FIELD, HIGH_PAD)
    |=> s.flags[5])
    else $error("channel C over flag missing");

  // Channel B over flag.
  a_over_b: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[1] > thr16(HIGH_FIELD, HIGH_PAD)
    |=> s.flags[3])
    else $error("channel B over flag missing");

  // Channel C under flag uses the zero padded low threshold.
  a_under_c: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[2] < thr16(LOW_FIELD, LOW_PAD)
    |=> s.flags[4])
    else $error("channel C under flag missing");

  // Channel B under flag.
  a_under_b: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[1] < thr16(LOW_FIELD, LOW_PAD)
    |=> s.flags[2])
    else $error("channel B under flag missing");

  // Channel A over flag sits at bit 1.
  a_over_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    RESULT_VALID && CHAN_RESULT[0] > thr16(HIGH_FIELD, HIGH_PAD)
    |=> s.flags[1])
    else $error("channel A over flag missing");

  // A status read must never drop the load fail flag.
  a_setup_read: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read ##0 !hard_take ##0 s.flags[BIT_SETUP]
    |=> s.flags[BIT_SETUP])
    else $error("load fail flag cleared by read");

  // The status word carries the flags held when the read was built.
  a_status_snap: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read |-> AVS_READDATA[FLAG_W-1:0] == $past(s.flags))
    else $error("status flags do not match register");

  // Every sticky bit that the host saw is gone after a quiet read.
  a_read_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_status_read ##0 s_quiet
    |=> (s.flags & $past(s.snap) & STICKY_MASK) == '0)
    else $error("read did not clear returned flags");

  // Hard reset clears all flags and the interrupt enables.
  a_hard_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    hard_take ##0 s_quiet
    |=> s.flags == FLAGS_RESET && s.irq_en == FLAGS_RESET)
    else $error("hard reset left state behind");

  // The setup restart strobe is a single cycle wide.
  a_restart_pulse: assert property (@(posedge MCLK) disable iff (!RST_N)
    SETUP_RESTART |=> !SETUP_RESTART)
    else $error("setup restart longer than one cycle");

  // Setup restarts only because the host asked for a hard reset.
  a_restart_cause: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(SETUP_RESTART) |-> $past(hard_take))
    else $error("setup restart without hard reset");

  // An enabled event raises the interrupt on the next cycle.
  a_irq_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
    (set_vec & s.irq_en) != '0 && !take |=> IRQ)
    else $error("enabled event did not raise interrupt");

  // Writing ones to the clear register drops those status bits.
  a_irq_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    take && AVS.write && AVS.address == OFF_IRQ_CLR &&
    AVS.byteenable[1:0] == 2'h3 ##0 s_quiet
    |=> (s.irq_stat & $past(AVS.writedata[FLAG_W-1:0])) == '0)
    else $error("interrupt status not cleared");

  // A checksum reject is also recorded for the interrupt.
  a_wchk_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    CRC_REJECT |=> s.irq_stat[BIT_WCHK])
    else $error("write check event missing in irq status");

  // A load failure is also recorded for the interrupt.
  a_setup_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
    SETUP_LOAD_FAIL |=> s.irq_stat[BIT_SETUP])
    else $error("load fail event missing in irq status");

endmodule
`default_nettype wire

// ==== test/host_model.sv ====
// Purpose: Host side of the register bus, one access at a time.
// Assumes: The slave answers within twenty cycles.
// Notes: Released address and data lines show inverted values, so stale data never passes.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import alert_pkg::*;
(
  input wire logic MCLK,
  input wire logic AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  output var avs_req_s AVS
);
  // Reset codes and status reads both travel through this task.
  task automatic acc(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r, output bit ok);
    ok = 0;
    r = '0;
    @(posedge MCLK);
    AVS <= '{read: !w, write: w, address: a, byteenable: 4'hF,
             writedata: d};
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge MCLK);
      if (AVS_WAITREQUEST === 1'b0) begin
        ok = 1;
        r = AVS_READDATA;
        AVS <= '{read: 1'b0, write: 1'b0, address: ~a, byteenable: 4'h0,
                 writedata: ~d};
      end
    end
  endtask
  // The bus starts idle.
  initial AVS = '{default: '0};
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: Self-checking bench for the alert status flags.
// Assumes: One scenario lands an event on the edge a status read ends.
// Notes: Flags are tracked in integers and compared after each read.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== 32'(e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", n, 32'(e), a); end end
module tb
  import alert_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic crc_rej = 1'b0;
  logic load_fail = 1'b0;
  logic rvalid = 1'b0;
  chan_results_t res = '0;
  logic [11:0] low = 12'h000;
  logic [11:0] high = 12'hFFF;
  logic wreq, restart, irq;
  logic [31:0] rdata, rd;
  avs_req_s avs;
  int num_errors = 0;
  int n_tests = 0;
  int flags = 0;
  int istat = 0;
  int ien = 0;
  bit ok;
  logic [31:0] seed = 32'hEA0B;
  chan_results_t v;
  logic [11:0] lo, hi;
  // A free-running clock at 100 MHz.
  always #5 mclk = ~mclk;
  alert_status_flags DUT (.MCLK(mclk), .RST_N(rst_n), .AVS(avs),
    .AVS_WAITREQUEST(wreq), .AVS_READDATA(rdata), .CRC_REJECT(crc_rej),
    .SETUP_LOAD_FAIL(load_fail), .RESULT_VALID(rvalid), .CHAN_RESULT(res),
    .LOW_FIELD(low), .HIGH_FIELD(high), .SETUP_RESTART(restart), .IRQ(irq));
  host_model host (.MCLK(mclk), .AVS_WAITREQUEST(wreq),
    .AVS_READDATA(rdata), .AVS(avs));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // A lost answer counts as a mismatch and ends the run at once.
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    host.acc(w, a, d, rd, ok);
    if (!ok) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // Only the load fail flag survives a status read in the model.
  task chk_stat;
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK("status", {STATUS_ADDR_CODE, 2'b00, 10'(flags)}, rd)
    flags &= 32'h100;
  endtask
  task pulse(input bit c, input bit l);
    @(posedge mclk);
    crc_rej <= c;
    load_fail <= l;
    @(posedge mclk);
    crc_rej <= 1'b0;
    load_fail <= 1'b0;
    flags |= (int'(c) << 9) | (int'(l) << 8);
    istat |= (int'(c) << 9) | (int'(l) << 8);
  endtask
  // Compares are strict, so a result equal to a threshold raises nothing.
  task sample;
    @(posedge mclk);
    rvalid <= 1'b1;
    res <= v;
    low <= lo;
    high <= hi;
    @(posedge mclk);
    rvalid <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (v[c] < {lo, 4'h0}) flags |= 1 << (2 * c);
      if (v[c] > {hi, 4'hF}) flags |= 2 << (2 * c);
    end
    istat |= flags & 32'h2FF;
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    chk_stat();
    pulse(1, 0);
    chk_stat();
    chk_stat();
    pulse(0, 1);
    chk_stat();
    chk_stat();
    pulse(1, 0);
    bus(1'b1, OFF_RESET, 32'(RST_SOFT));
    flags &= 32'h100;
    chk_stat();
    bus(1'b1, OFF_IRQ_EN, 32'h3FF);
    bus(1'b1, OFF_RESET, 32'(RST_HARD));
    #1 `CHK("restart", 1, restart)
    flags = 0;
    chk_stat();
    bus(1'b0, OFF_IRQ_EN, 32'h0);
    `CHK("irq enable", 0, rd)
    bus(1'b1, OFF_IRQ_EN, 32'h3FF);
    ien = 32'h3FF;
    for (int i = 0; i < 24; i++) begin
      lo = rnd();
      hi = rnd();
      v = {rnd(), rnd()};
      if (i == 0) v = {{hi, 4'hF} + 16'h1, {lo, 4'h0} - 16'h1, {hi, 4'hF},
                       {lo, 4'h0}};
      sample();
      chk_stat();
    end
    // A reject on the edge that ends a read must survive the clear.
    fork
      chk_stat();
      begin
        repeat (2) @(posedge mclk);
        crc_rej <= 1'b1;
        @(posedge mclk);
        crc_rej <= 1'b0;
      end
    join
    flags |= 32'h200;
    istat |= 32'h200;
    chk_stat();
    bus(1'b0, OFF_IRQ_STAT, 32'h0);
    `CHK("irq status", istat, rd)
    #1 `CHK("irq on", (istat & ien) != 0, irq)
    bus(1'b1, OFF_IRQ_EN, 32'h0);
    #1 `CHK("irq masked", 0, irq)
    bus(1'b1, OFF_IRQ_EN, 32'h3FF);
    bus(1'b1, OFF_IRQ_CLR, 32'h3FF);
    #1 `CHK("irq cleared", 0, irq)
    bus(1'b0, 5'h14, 32'h0);
    `CHK("unmapped", 0, rd)
    give_verdict();
  end
endmodule
`default_nettype wire
